// ==== rtl/oswp_pkg.sv ====
package oswp_pkg;

  // clock and crystal supervision timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int XTAL_STOP_NS = 1000;
  localparam int XTAL_STOP_CYC = (XTAL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CPU_DIV_SLOW = 8;

  // register indices, byte address is index times four
  localparam logic [5:0] IDX_CLK_MODE_A = 6'h00;
  localparam logic [5:0] IDX_CLK_MODE_B = 6'h01;
  localparam logic [5:0] IDX_OSC_STOP_DETECT_CTRL = 6'h02;
  localparam logic [5:0] IDX_ONCHIP_OSC_CTRL_A = 6'h03;
  localparam logic [5:0] IDX_ONCHIP_OSC_CTRL_B = 6'h04;
  localparam logic [5:0] IDX_ONCHIP_OSC_CTRL_C = 6'h05;
  localparam logic [5:0] IDX_PROC_MODE_A = 6'h06;
  localparam logic [5:0] IDX_PROC_MODE_B = 6'h07;
  localparam logic [5:0] IDX_PORT0_DIRECTION = 6'h08;
  localparam logic [5:0] IDX_VOLT_DETECT_CTRL = 6'h09;
  localparam logic [5:0] IDX_WRITE_PROTECT = 6'h0a;
  localparam logic [5:0] IDX_VOLT_MON_ONE_CTRL = 6'h0b;
  localparam logic [5:0] IDX_VOLT_MON_TWO_CTRL = 6'h0c;
  localparam logic [5:0] IDX_STATUS = 6'h0d;

  // field positions
  localparam int BIT_PERIPH_CLOCK_STOP_IN_WAIT = 2;
  localparam int BIT_ONCHIP_SOURCE_SELECT = 3;
  localparam int BIT_CRYSTAL_STOP = 5;
  localparam int BIT_DIV8_MODE = 6;
  localparam int BIT_STOP_REQUEST = 0;
  localparam int BIT_LOW_SPEED_OSC_OFF = 4;
  localparam int BIT_DETECT_ENABLE_LSB = 0;
  localparam int BIT_DETECT_ENABLE_MSB = 1;
  localparam int BIT_CLOCK_SELECT_STATUS = 2;
  localparam int BIT_CRYSTAL_STOPPED = 3;
  localparam int BIT_HIGH_SPEED_OSC_ENABLE = 0;
  localparam int BIT_ONCHIP_SPEED_SELECT = 1;
  localparam int BIT_CLOCK_PROTECT = 0;
  localparam int BIT_PROC_MODE_PROTECT = 1;
  localparam int BIT_PORT_DIR_PROTECT = 2;
  localparam int BIT_VOLT_MON_PROTECT = 3;
  localparam int BIT_VOLT_MON_FLAG = 2;
  localparam int BIT_WATCHDOG_EVENT = 3;

  // masks and reset values
  localparam logic [7:0] PROTECT_RW_MASK = 8'h3f;
  localparam logic [1:0] DETECT_ENABLED = 2'h3;
  localparam logic [7:0] CLK_MODE_A_RESET = 8'h40;
  localparam logic [7:0] CLK_MODE_B_RESET = 8'h00;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [31:0] DATA32_ZERO = 32'h0000_0000;

  // power control states
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STOP = 3'b010,
    ST_RESTART = 3'b100
  } oswp_state_t;

endpackage

// ==== rtl/oswp_top.sv ====
// Functional notes
// R1 - stop mode ends only on reset or an enabled peripheral interrupt request
// R2 - software sets wake priorities, other priorities 000b, global enable, starts peripheral
// R3 - interrupt sequence starts after request and CPU clock restart
// R4 - after interrupt wake-up CPU clock is prior system clock divided by 8
// R5 - crystal stop detection active only while enable field is 11b
// R6 - on stop: select on-chip clock, set stopped flag, start low-speed oscillator, interrupt
// R7 - detection needs crystal of at least 2 MHz, else software keeps field 00b
// R8 - oscillation stop shares one vector with watchdog and voltage monitors
// R9 - each shared-vector source has its own readable status bit
// R10 - no automatic return to crystal; software reselects it
// R11 - software keeps peripheral clock stop in wait at 0 while detecting
// R12 - software clears enable field before starting or stopping the crystal itself
// R13 - software picks fallback oscillator speed before writing 11b to enable field
// R14 - four bytes prefetched after stop request; flash rewrite off, jump, four nops
// R15 - four bytes prefetched after wait; flash rewrite off, four nops after it
// R16 - clock, detect and on-chip oscillator registers writable only with clock protect set
// R17 - processor mode needs protect bit one, voltage monitor needs protect bit three
// R18 - port direction protect clears after next write anywhere; others stay set
// R19 - protect bits b5-b4 written as 0, bits b7-b6 read as 0
// R20 - blocked protected write leaves register unchanged and gives no error
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
module oswp_top
  import oswp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic crystal_clock_i,
  input wire logic periph_wake_req_i,
  input wire logic watchdog_event_i,
  input wire logic volt_mon_one_event_i,
  input wire logic volt_mon_two_event_i,
  output logic cpu_clk_en_o,
  output logic cpu_src_onchip_o,
  output logic stop_mode_o,
  output logic irq_seq_start_o,
  output logic shared_irq_o,
  output logic low_speed_osc_off_o,
  output logic crystal_stop_o,
  output logic periph_clock_stop_in_wait_o,
  output logic [7:0] port0_direction_o
);

  import oswp_pkg::*;

  logic [7:0] clock_mode_reg_a_r, clock_mode_reg_b_r, osc_stop_detect_ctrl_r;
  logic [7:0] onchip_osc_ctrl_a_r, onchip_osc_ctrl_b_r, onchip_osc_ctrl_c_r;
  logic [7:0] proc_mode_reg_a_r, proc_mode_reg_b_r, port0_direction_r;
  logic [7:0] volt_detect_ctrl_r, volt_mon_one_ctrl_r, volt_mon_two_ctrl_r;
  logic [7:0] register_write_protect_r;
  oswp_state_t state_r;
  logic [2:0] div_cnt_r;
  logic wake_pend_r;
  logic xtal_stop_pulse;
  logic wr_stb;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic detect_on;
  logic osc_stop_hit;

  // write permission per register index
  function automatic logic wr_allowed(input logic [5:0] i, input logic [7:0] prot);
    logic ok;
    ok = 1'b1;
    case (i)
      IDX_CLK_MODE_A, IDX_CLK_MODE_B, IDX_OSC_STOP_DETECT_CTRL,
      IDX_ONCHIP_OSC_CTRL_A, IDX_ONCHIP_OSC_CTRL_B, IDX_ONCHIP_OSC_CTRL_C:
        ok = prot[BIT_CLOCK_PROTECT]; // R16
      IDX_PROC_MODE_A, IDX_PROC_MODE_B:
        ok = prot[BIT_PROC_MODE_PROTECT]; // R17
      IDX_PORT0_DIRECTION:
        ok = prot[BIT_PORT_DIR_PROTECT]; // R18
      IDX_VOLT_DETECT_CTRL, IDX_VOLT_MON_ONE_CTRL, IDX_VOLT_MON_TWO_CTRL:
        ok = prot[BIT_VOLT_MON_PROTECT]; // R17
      default:
        ok = 1'b1;
    endcase
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: a write lands at the edge where ack is given
  assign idx = wb_adr_i[7:2];
  assign wdat = wb_dat_i[7:0];
  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                  && wr_allowed(idx, register_write_protect_r); // R20
  assign detect_on = (osc_stop_detect_ctrl_r[BIT_DETECT_ENABLE_MSB:BIT_DETECT_ENABLE_LSB]
                      == DETECT_ENABLED); // R5
  assign osc_stop_hit = xtal_stop_pulse && detect_on
                        && !osc_stop_detect_ctrl_r[BIT_CLOCK_SELECT_STATUS]
                        && !clock_mode_reg_a_r[BIT_ONCHIP_SOURCE_SELECT]; // R6

  oswp_xtal_mon u_xtal_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .crystal_clock_i(crystal_clock_i),
    .enable_i(detect_on),
    .stopped_o(xtal_stop_pulse)
  );

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // read data mux, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= DATA32_ZERO;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      wb_dat_o <= DATA32_ZERO;
      case (idx)
        IDX_CLK_MODE_A: wb_dat_o[7:0] <= clock_mode_reg_a_r;
        IDX_CLK_MODE_B: wb_dat_o[7:0] <= clock_mode_reg_b_r;
        IDX_OSC_STOP_DETECT_CTRL: wb_dat_o[7:0] <= osc_stop_detect_ctrl_r; // R9
        IDX_ONCHIP_OSC_CTRL_A: wb_dat_o[7:0] <= onchip_osc_ctrl_a_r;
        IDX_ONCHIP_OSC_CTRL_B: wb_dat_o[7:0] <= onchip_osc_ctrl_b_r;
        IDX_ONCHIP_OSC_CTRL_C: wb_dat_o[7:0] <= onchip_osc_ctrl_c_r;
        IDX_PROC_MODE_A: wb_dat_o[7:0] <= proc_mode_reg_a_r;
        IDX_PROC_MODE_B: wb_dat_o[7:0] <= proc_mode_reg_b_r;
        IDX_PORT0_DIRECTION: wb_dat_o[7:0] <= port0_direction_r;
        IDX_VOLT_DETECT_CTRL: wb_dat_o[7:0] <= volt_detect_ctrl_r;
        IDX_WRITE_PROTECT: wb_dat_o[7:0] <= register_write_protect_r & PROTECT_RW_MASK; // R19
        IDX_VOLT_MON_ONE_CTRL: wb_dat_o[7:0] <= volt_mon_one_ctrl_r; // R9
        IDX_VOLT_MON_TWO_CTRL: wb_dat_o[7:0] <= volt_mon_two_ctrl_r; // R9
        IDX_STATUS: wb_dat_o[2:0] <= state_r;
        default: wb_dat_o <= DATA32_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protect register, port direction bit clears after next write anywhere
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      register_write_protect_r <= REG8_RESET;
    else if (wr_stb && idx == IDX_WRITE_PROTECT)
      register_write_protect_r <= wdat & PROTECT_RW_MASK; // R19
    else if (wr_stb || (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i))
      register_write_protect_r[BIT_PORT_DIR_PROTECT] <= 1'b0; // R18
  end

  // plain protected registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      onchip_osc_ctrl_a_r <= REG8_RESET;
      onchip_osc_ctrl_b_r <= REG8_RESET;
      onchip_osc_ctrl_c_r <= REG8_RESET;
      proc_mode_reg_a_r <= REG8_RESET;
      proc_mode_reg_b_r <= REG8_RESET;
      port0_direction_r <= REG8_RESET;
      volt_detect_ctrl_r <= REG8_RESET;
    end
    else if (wr_stb)
    begin
      case (idx)
        IDX_ONCHIP_OSC_CTRL_A: onchip_osc_ctrl_a_r <= wdat; // R16
        IDX_ONCHIP_OSC_CTRL_B: onchip_osc_ctrl_b_r <= wdat; // R16
        IDX_ONCHIP_OSC_CTRL_C: onchip_osc_ctrl_c_r <= wdat; // R16
        IDX_PROC_MODE_A: proc_mode_reg_a_r <= wdat; // R17
        IDX_PROC_MODE_B: proc_mode_reg_b_r <= wdat; // R17
        IDX_PORT0_DIRECTION: port0_direction_r <= wdat; // R18
        IDX_VOLT_DETECT_CTRL: volt_detect_ctrl_r <= wdat; // R17
        default: ;
      endcase
    end
  end

  // voltage monitor controls with sticky event flags, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      volt_mon_one_ctrl_r <= REG8_RESET;
      volt_mon_two_ctrl_r <= REG8_RESET;
    end
    else
    begin
      if (wr_stb && idx == IDX_VOLT_MON_ONE_CTRL)
        volt_mon_one_ctrl_r <= wdat; // R17
      if (wr_stb && idx == IDX_VOLT_MON_TWO_CTRL)
        volt_mon_two_ctrl_r <= wdat; // R17
      if (volt_mon_one_event_i)
        volt_mon_one_ctrl_r[BIT_VOLT_MON_FLAG] <= 1'b1; // R9
      if (volt_mon_two_event_i)
        volt_mon_two_ctrl_r[BIT_VOLT_MON_FLAG] <= 1'b1; // R9
      if (watchdog_event_i)
        volt_mon_two_ctrl_r[BIT_WATCHDOG_EVENT] <= 1'b1; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection control: fallback switch and stopped flag on crystal loss
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      osc_stop_detect_ctrl_r <= REG8_RESET;
    else
    begin
      if (wr_stb && idx == IDX_OSC_STOP_DETECT_CTRL)
        osc_stop_detect_ctrl_r <= wdat; // R16
      if (osc_stop_hit)
      begin
        osc_stop_detect_ctrl_r[BIT_CLOCK_SELECT_STATUS] <= 1'b1; // R6
        osc_stop_detect_ctrl_r[BIT_CRYSTAL_STOPPED] <= 1'b1; // R6
      end
    end
  end

  // clock mode registers, stop entry and wake-up side effects
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_mode_reg_a_r <= CLK_MODE_A_RESET;
      clock_mode_reg_b_r <= CLK_MODE_B_RESET;
    end
    else
    begin
      if (wr_stb && idx == IDX_CLK_MODE_A)
        clock_mode_reg_a_r <= wdat; // R16
      if (wr_stb && idx == IDX_CLK_MODE_B)
      begin
        clock_mode_reg_b_r <= wdat; // R16
        if (wdat[BIT_STOP_REQUEST])
          clock_mode_reg_a_r[BIT_DIV8_MODE] <= 1'b1; // R4
      end
      if (osc_stop_hit)
        clock_mode_reg_b_r[BIT_LOW_SPEED_OSC_OFF] <= 1'b0; // R6
      if (state_r == ST_STOP && periph_wake_req_i)
        clock_mode_reg_b_r[BIT_STOP_REQUEST] <= 1'b0; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state: run, stop, clock restart before interrupt sequence
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_RUN;
      wake_pend_r <= 1'b0;
      irq_seq_start_o <= 1'b0;
    end
    else
    begin
      irq_seq_start_o <= 1'b0;
      case (state_r)
        ST_RUN:
          if (clock_mode_reg_b_r[BIT_STOP_REQUEST]) // R14
            state_r <= ST_STOP;
        ST_STOP:
          if (periph_wake_req_i) // R1
          begin
            state_r <= ST_RESTART;
            wake_pend_r <= 1'b1;
          end
        ST_RESTART:
          if (cpu_clk_en_o) // R3
          begin
            state_r <= ST_RUN;
            wake_pend_r <= 1'b0;
            irq_seq_start_o <= wake_pend_r; // R3
          end
        default:
          state_r <= ST_RUN;
      endcase
    end
  end

  // cpu clock enable divider, none in stop mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt_r <= 3'h0;
      cpu_clk_en_o <= 1'b0;
    end
    else if (state_r == ST_STOP)
    begin
      div_cnt_r <= 3'h0;
      cpu_clk_en_o <= 1'b0;
    end
    else if (clock_mode_reg_a_r[BIT_DIV8_MODE])
    begin
      div_cnt_r <= div_cnt_r + 3'h1;
      cpu_clk_en_o <= (div_cnt_r == 3'(CPU_DIV_SLOW - 1)); // R4
    end
    else
    begin
      div_cnt_r <= 3'h0;
      cpu_clk_en_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared vector request and registered control outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shared_irq_o <= 1'b0;
      stop_mode_o <= 1'b0;
      cpu_src_onchip_o <= 1'b0;
      low_speed_osc_off_o <= 1'b0;
      crystal_stop_o <= 1'b0;
      periph_clock_stop_in_wait_o <= 1'b0;
      port0_direction_o <= REG8_RESET;
    end
    else
    begin
      shared_irq_o <= (osc_stop_detect_ctrl_r[BIT_CRYSTAL_STOPPED] && detect_on)
                      || volt_mon_two_ctrl_r[BIT_WATCHDOG_EVENT]
                      || volt_mon_one_ctrl_r[BIT_VOLT_MON_FLAG]
                      || volt_mon_two_ctrl_r[BIT_VOLT_MON_FLAG]; // R8
      stop_mode_o <= (state_r == ST_STOP);
      cpu_src_onchip_o <= osc_stop_detect_ctrl_r[BIT_CLOCK_SELECT_STATUS]
                          || clock_mode_reg_a_r[BIT_ONCHIP_SOURCE_SELECT]; // R10
      low_speed_osc_off_o <= clock_mode_reg_b_r[BIT_LOW_SPEED_OSC_OFF];
      crystal_stop_o <= clock_mode_reg_a_r[BIT_CRYSTAL_STOP];
      periph_clock_stop_in_wait_o <= clock_mode_reg_a_r[BIT_PERIPH_CLOCK_STOP_IN_WAIT]; // R15
      port0_direction_o <= port0_direction_r;
    end
  end

endmodule

// ==== rtl/oswp_xtal_mon.sv ====
`timescale 1ns/1ps
module oswp_xtal_mon
  import oswp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic crystal_clock_i,
  input wire logic enable_i,
  output logic stopped_o
);

  logic sync1_r, sync2_r, sync3_r, level_r;
  logic [7:0] quiet_cnt_r;
  logic edge_seen;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchroniser for the crystal pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end
    else
    begin
      sync1_r <= crystal_clock_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_r <= 1'b0;
    else if (sync2_r == sync3_r)
      level_r <= sync3_r;
  end

  assign edge_seen = (sync2_r == sync3_r) && (sync3_r != level_r);

  ////////////////////////////////////////////////////////////////////////////
  // quiet-time counter, one pulse when the crystal goes silent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      quiet_cnt_r <= 8'h00;
      stopped_o <= 1'b0;
    end
    else
    begin
      stopped_o <= 1'b0;
      if (!enable_i || edge_seen)
        quiet_cnt_r <= 8'h00;
      else if (quiet_cnt_r != 8'(XTAL_STOP_CYC))
      begin
        quiet_cnt_r <= quiet_cnt_r + 8'h01;
        stopped_o <= (quiet_cnt_r == 8'(XTAL_STOP_CYC - 1));
      end
    end
  end

endmodule

// ==== test/oswp_checker.sv ====
`timescale 1ns/1ps
module oswp_checker
  import oswp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic periph_wake_req_i,
  input wire logic watchdog_event_i,
  input wire logic cpu_clk_en_o,
  input wire logic cpu_src_onchip_o,
  input wire logic stop_mode_o,
  input wire logic irq_seq_start_o,
  input wire logic shared_irq_o,
  input wire logic low_speed_osc_off_o,
  input wire logic periph_clock_stop_in_wait_o,
  input wire logic [7:0] port0_direction_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // bus answer
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  // stop and wake
  property p_stay_stop;
    stop_mode_o && !periph_wake_req_i && !$past(periph_wake_req_i) |=> stop_mode_o;
  endproperty
  a_stay_stop: assert property (p_stay_stop) else $error("stop left without wake");
  property p_irq_en; irq_seq_start_o |-> $past(cpu_clk_en_o); endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq before clock restart");
  property p_wake; stop_mode_o && periph_wake_req_i |-> ##[1:12] irq_seq_start_o; endproperty
  a_wake: assert property (p_wake) else $error("no irq sequence after wake");
  property p_div8; irq_seq_start_o |-> !cpu_clk_en_o [*7] ##1 cpu_clk_en_o; endproperty
  a_div8: assert property (p_div8) else $error("cpu clock not divided by 8");
  // crystal stop fallback
  property p_fall;
    $rose(cpu_src_onchip_o) |-> ##[0:2] !low_speed_osc_off_o ##[0:3] shared_irq_o;
  endproperty
  a_fall: assert property (p_fall) else $error("fallback incomplete");
  property p_no_ret;
    cpu_src_onchip_o && !wb_cyc_i && !$past(wb_cyc_i) |=> cpu_src_onchip_o;
  endproperty
  a_no_ret: assert property (p_no_ret) else $error("source switched back alone");
  property p_wd; watchdog_event_i |-> ##[1:3] shared_irq_o; endproperty
  a_wd: assert property (p_wd) else $error("watchdog not on shared vector");
  // protected outputs move only after a write
  property p_dir;
    !$stable(port0_direction_o) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_dir: assert property (p_dir) else $error("port direction changed alone");
  property p_wait;
    !$stable(periph_clock_stop_in_wait_o) |->
      $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_wait: assert property (p_wait) else $error("clock mode bit changed alone");
  c_irq: cover property (irq_seq_start_o);
  c_fall: cover property ($rose(cpu_src_onchip_o));
  c_wd: cover property (watchdog_event_i ##2 shared_irq_o);
endmodule
bind oswp_top oswp_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .periph_wake_req_i, .watchdog_event_i, .cpu_clk_en_o, .cpu_src_onchip_o, .stop_mode_o,
  .irq_seq_start_o, .shared_irq_o, .low_speed_osc_off_o, .periph_clock_stop_in_wait_o,
  .port0_direction_o);

// ==== test/oswp_xtal_model.sv ====
`timescale 1ns/1ps
module oswp_xtal_model #(parameter int HALF_NS = 50)
(
  input wire logic run_i,
  output logic crystal_clock_o
);
  // 10 MHz crystal; a stopped crystal holds its last level
  initial
  begin
    crystal_clock_o = 1'b0;
    forever
    begin
      #(HALF_NS);
      if (run_i)
        crystal_clock_o = ~crystal_clock_o;
    end
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import oswp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic [2:0] ev = 3'b000;
  logic xtal_run = 1'b1;
  logic wake = 1'b0;
  logic wb_ack_o, crystal_clock_i, cpu_clk_en_o, cpu_src_onchip_o, stop_mode_o;
  logic irq_seq_start_o, shared_irq_o, low_speed_osc_off_o, crystal_stop_o, pcsw;
  logic [7:0] port0_direction_o;
  logic [7:0] mdl [0:63] = '{default: 8'h00};
  logic [7:0] ev_adr [3] = '{8'h30, 8'h2c, 8'h30};
  logic [31:0] ev_bit [3] = '{32'h0000_0008, 32'h0000_0004, 32'h0000_0004};
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int a, k;
  oswp_xtal_model i_xtal (.run_i(xtal_run), .crystal_clock_o(crystal_clock_i));
  oswp_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .crystal_clock_i, .periph_wake_req_i(wake),
    .watchdog_event_i(ev[0]), .volt_mon_one_event_i(ev[1]), .volt_mon_two_event_i(ev[2]),
    .cpu_clk_en_o, .cpu_src_onchip_o, .stop_mode_o, .irq_seq_start_o, .shared_irq_o,
    .low_speed_osc_off_o, .crystal_stop_o, .periph_clock_stop_in_wait_o(pcsw),
    .port0_direction_o);
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // protect model: gate, then auto-clear of port direction protect
  function automatic void mdl_wr(input int i, input logic [7:0] d);
    logic ok;
    ok = (i <= 5) ? mdl[10][0] : (i == 6 || i == 7) ? mdl[10][1] :
      (i == 8) ? mdl[10][2] : (i == 9 || i == 11 || i == 12) ? mdl[10][3] : 1'b0;
    if (i != 10)
      mdl[10][2] = 1'b0;
    if (i == 10)
      mdl[10] = d & 8'h3f;
    else if (ok)
      mdl[i] = d;
  endfunction
  // classic single cycle, held until ack is sampled
  task automatic wbx(input logic we, input logic [7:0] adr, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (we)
      mdl_wr(adr[7:2], d);
  endtask
  task automatic rdc(input logic [7:0] adr);
    wbx(1'b0, adr, 8'h00);
    chk(rd, {24'h00_0000, mdl[adr[7:2]]});
  endtask
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(54426));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h28);
    wbx(1'b0, 8'h00, 8'h00);
    chk(rd, 32'h0000_0040);
    // clock mode write blocked, then allowed; port direction protect self-clears
    wbx(1'b1, 8'h00, 8'h64);
    @(negedge clk_i);
    chk(pcsw, 1'b0);
    chk(crystal_stop_o, 1'b0);
    wbx(1'b1, 8'h28, 8'h05);
    wbx(1'b1, 8'h20, 8'h5a);
    wbx(1'b1, 8'h00, 8'h64);
    @(negedge clk_i);
    chk(pcsw, 1'b1);
    chk(crystal_stop_o, 1'b1);
    chk(port0_direction_o, mdl[8]);
    rdc(8'h28);
    wbx(1'b1, 8'h00, 8'h40);
    @(negedge clk_i);
    chk(pcsw, 1'b0);
    $display("test reset done");
    for (int n = 0; n < 80; n++)
    begin
      a = $urandom_range(12, 3);
      a = (a == 11) ? 10 : (a == 12) ? 63 : a;
      k = (a == 10) ? ($urandom & 32'h0000_000f) : $urandom;
      wbx(1'b1, 8'(a * 4), 8'(k));
      rdc(8'(a * 4));
      rdc(8'h28);
      chk(port0_direction_o, mdl[8]);
    end
    $display("test protect done");
    wbx(1'b1, 8'h28, 8'h01);
    wbx(1'b1, 8'h0c, 8'h00);
    wbx(1'b1, 8'h04, 8'h10);
    wbx(1'b1, 8'h08, 8'h01);
    xtal_run <= 1'b0;
    repeat (200) @(negedge clk_i);
    chk(cpu_src_onchip_o, 1'b0);
    chk(low_speed_osc_off_o, 1'b1);
    wbx(1'b1, 8'h08, 8'h03);
    for (k = 0; k < 200 && cpu_src_onchip_o !== 1'b1; k++) @(negedge clk_i);
    repeat (3) @(negedge clk_i);
    chk(cpu_src_onchip_o, 1'b1);
    chk(low_speed_osc_off_o, 1'b0);
    chk(shared_irq_o, 1'b1);
    chk(pcsw, 1'b0);
    wbx(1'b0, 8'h08, 8'h00);
    chk(rd, 32'h0000_000f);
    xtal_run <= 1'b1;
    repeat (100) @(negedge clk_i);
    chk(cpu_src_onchip_o, 1'b1);
    wbx(1'b1, 8'h08, 8'h00);
    @(negedge clk_i);
    chk(shared_irq_o, 1'b0);
    $display("test crystal done");
    wbx(1'b1, 8'h28, 8'h09);
    for (int s = 0; s < 3; s++)
    begin
      @(posedge clk_i);
      ev[s] <= 1'b1;
      @(posedge clk_i);
      ev[s] <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk(shared_irq_o, 1'b1);
      wbx(1'b0, ev_adr[s], 8'h00);
      chk(rd, ev_bit[s]);
      wbx(1'b1, ev_adr[s], 8'h00);
      @(negedge clk_i);
      chk(shared_irq_o, 1'b0);
    end
    $display("test vector done");
    wbx(1'b1, 8'h04, 8'h01);
    for (k = 0; k < 20 && stop_mode_o !== 1'b1; k++) @(negedge clk_i);
    repeat (30) @(negedge clk_i);
    chk(stop_mode_o, 1'b1);
    chk(cpu_clk_en_o, 1'b0);
    @(posedge clk_i);
    wake <= 1'b1;
    for (k = 0; k < 40 && irq_seq_start_o !== 1'b1; k++) @(negedge clk_i);
    chk(irq_seq_start_o, 1'b1);
    for (k = 0; k < 20 && !(k > 0 && cpu_clk_en_o === 1'b1); k++) @(negedge clk_i);
    chk(k, CPU_DIV_SLOW - 1);
    @(posedge clk_i);
    wake <= 1'b0;
    @(negedge clk_i);
    chk(stop_mode_o, 1'b0);
    $display("test stop done");
    give_verdict();
  end
endmodule
